// File: logic/pcr_consts.vh
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// Management address of the control register
`define PCR_ADDR_CONTROL 5'h00
// Control register reset value: 100 Mb/s, auto-negotiation, full duplex
`define PCR_CONTROL_RESET 16'h3100
// Field positions
`define PCR_BIT_SOFT_RESET 15
`define PCR_BIT_LOOPBACK 14
`define PCR_BIT_SPEED 13
`define PCR_BIT_ANEG_EN 12
`define PCR_BIT_POWER_DOWN 11
`define PCR_BIT_ISOLATE 10
`define PCR_BIT_ANEG_RESTART 9
`define PCR_BIT_DUPLEX 8
`define PCR_BIT_COLL_TEST 7
// Reserved low field 6:0 and its reset value
`define PCR_RSVD_MSB 6
`define PCR_RSVD_RESET 7'h00
// Value returned for an unlisted management address
`define PCR_UNMAPPED_READ 16'h0000
// Receive holding register reset value
`define PCR_RX_HOLD_RESET 16'h0000

`endif

// File: logic/pcr_phy_control.v
`timescale 1ns/100ps
`include "pcr_consts.vh"

module pcr_phy_control (
    clk,
    sys_rst,
    mgmt_start,
    mgmt_write,
    mgmt_addr,
    mgmt_tx_holding,
    mgmt_rx_holding,
    mgmt_done,
    aneg_full_resolved,
    aneg_restart_done,
    tx_initiated,
    tx_halted,
    phy_control,
    full_duplex,
    collision_test,
    loopback_enable,
    speed_select,
    autoneg_enable,
    power_down,
    isolate,
    autoneg_restart,
    soft_reset_pulse
);
    input wire clk;
    input wire sys_rst;
    input wire mgmt_start;
    input wire mgmt_write;
    input wire [4:0] mgmt_addr;
    input wire [15:0] mgmt_tx_holding;
    output reg [15:0] mgmt_rx_holding;
    output reg mgmt_done;
    input wire aneg_full_resolved;
    input wire aneg_restart_done;
    input wire tx_initiated;
    input wire tx_halted;
    output wire [15:0] phy_control;
    output wire full_duplex;
    output wire collision_test;
    output wire loopback_enable;
    output wire speed_select;
    output wire autoneg_enable;
    output wire power_down;
    output wire isolate;
    output wire autoneg_restart;
    output reg soft_reset_pulse;

    ////////////////////////////////////////////////////////////////////
    // Register state and next values
    reg [15:0] ctrl_q;
    reg [15:0] ctrl_d;
    reg [15:0] wr_value;
    reg [15:0] rd_value;
    reg restart_d;
    reg coll_d;
    reg duplex_d;

    // Decode and event strobes
    wire hit_ctrl;
    wire wr_ctrl;
    wire rd_req;
    wire soft_rst_pending;
    wire restart_clr;
    wire aneg_dup_set;

    // Write-or-hold choice shared by the bits that hardware also drives
    function pcr_pick;
        input cur;
        input wr_en;
        input wr_bit;
        begin
            pcr_pick = wr_en ? wr_bit : cur;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Transaction decode
    assign hit_ctrl = (mgmt_addr == `PCR_ADDR_CONTROL);
    assign wr_ctrl = mgmt_start & mgmt_write & hit_ctrl;
    assign rd_req = mgmt_start & ~mgmt_write;
    assign soft_rst_pending = ctrl_q[`PCR_BIT_SOFT_RESET];
    // Restart only completes while one is actually outstanding
    assign restart_clr = ctrl_q[`PCR_BIT_ANEG_RESTART] & aneg_restart_done;
    // Negotiation results are ignored while auto-negotiation is off
    assign aneg_dup_set = aneg_full_resolved & ctrl_q[`PCR_BIT_ANEG_EN];

    ////////////////////////////////////////////////////////////////////
    // Write value; the reserved low field never stores anything but zero
    always @* begin
        wr_value = mgmt_tx_holding;
        wr_value[`PCR_RSVD_MSB:0] = `PCR_RSVD_RESET;
    end

    ////////////////////////////////////////////////////////////////////
    // Events are applied after the write, so an event that falls in the
    // cycle of a clearing write is never lost
    always @* begin
        restart_d = pcr_pick(ctrl_q[`PCR_BIT_ANEG_RESTART], wr_ctrl,
            wr_value[`PCR_BIT_ANEG_RESTART]);
        if (restart_clr) begin
            restart_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Collision test: a transmission start beats a halt in one cycle
    always @* begin
        coll_d = pcr_pick(ctrl_q[`PCR_BIT_COLL_TEST], wr_ctrl,
            wr_value[`PCR_BIT_COLL_TEST]);
        if (tx_halted) begin
            coll_d = 1'b0;
        end
        if (tx_initiated) begin
            coll_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Duplex: software or a resolved full-duplex negotiation may set it
    always @* begin
        duplex_d = pcr_pick(ctrl_q[`PCR_BIT_DUPLEX], wr_ctrl,
            wr_value[`PCR_BIT_DUPLEX]);
        if (aneg_dup_set) begin
            duplex_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next register value; a pending soft reset overrides every source
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = wr_value;
        end
        // Hardware-owned bits take their merged value
        ctrl_d[`PCR_BIT_ANEG_RESTART] = restart_d;
        ctrl_d[`PCR_BIT_COLL_TEST] = coll_d;
        ctrl_d[`PCR_BIT_DUPLEX] = duplex_d;
        // Soft reset completes in one cycle: every field reloads defaults
        if (soft_rst_pending) begin
            ctrl_d = `PCR_CONTROL_RESET;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= `PCR_CONTROL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One-cycle notice to the rest of the PHY that the reload happened
    always @(posedge clk) begin
        if (sys_rst) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_rst_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path; unlisted addresses read as zero, software ignores them
    always @* begin
        rd_value = `PCR_UNMAPPED_READ;
        if (hit_ctrl) begin
            rd_value = ctrl_q;
        end
    end

    // Holds its word until the next read, whatever the address
    always @(posedge clk) begin
        if (sys_rst) begin
            mgmt_rx_holding <= `PCR_RX_HOLD_RESET;
        end else if (rd_req) begin
            mgmt_rx_holding <= rd_value;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Every transaction, mapped or not, is answered one cycle later
    always @(posedge clk) begin
        if (sys_rst) begin
            mgmt_done <= 1'b0;
        end else begin
            mgmt_done <= mgmt_start;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register image and the bits that steer the rest of the PHY
    assign phy_control = ctrl_q;
    assign full_duplex = ctrl_q[`PCR_BIT_DUPLEX];
    assign collision_test = ctrl_q[`PCR_BIT_COLL_TEST];

    // Configuration bits plus the hardware-cleared restart bit; their effect lives elsewhere in the PHY
    assign loopback_enable = ctrl_q[`PCR_BIT_LOOPBACK];
    assign speed_select = ctrl_q[`PCR_BIT_SPEED];
    assign autoneg_enable = ctrl_q[`PCR_BIT_ANEG_EN];
    assign power_down = ctrl_q[`PCR_BIT_POWER_DOWN];
    assign isolate = ctrl_q[`PCR_BIT_ISOLATE];
    assign autoneg_restart = ctrl_q[`PCR_BIT_ANEG_RESTART];

endmodule // pcr_phy_control

// File: verif/pcr_mac_model.sv
`timescale 1ns/100ps
module pcr_mac(
    input logic clk,
    output logic mgmt_start = 1'b0,
    output logic mgmt_write = 1'b0,
    output logic [4:0] mgmt_addr = 5'h00,
    output logic [15:0] mgmt_tx_holding = 16'h0000
);
    task automatic xfer(input logic w, input logic [4:0] a,
        input logic [15:0] d);
        @(negedge clk);
        mgmt_start = 1;
        mgmt_write = w;
        mgmt_addr = a;
        mgmt_tx_holding = w ? d & 16'hff80 : ~d;
        @(negedge clk);
        mgmt_start = 0;
        mgmt_tx_holding = ~mgmt_tx_holding; // Stale data, not a repeat
    endtask
endmodule // pcr_mac

// File: verif/pcr_phy_control_monitor.sv
`timescale 1ns/100ps
module pcr_mon(
    input logic clk,
    input logic sys_rst,
    input logic mgmt_start,
    input logic mgmt_write,
    input logic [4:0] mgmt_addr,
    input logic [15:0] mgmt_tx_holding,
    input logic [15:0] mgmt_rx_holding,
    input logic mgmt_done,
    input logic aneg_full_resolved,
    input logic aneg_restart_done,
    input logic tx_initiated,
    input logic tx_halted,
    input logic [15:0] phy_control,
    input logic full_duplex,
    input logic collision_test,
    input logic loopback_enable,
    input logic speed_select,
    input logic autoneg_enable,
    input logic power_down,
    input logic isolate,
    input logic autoneg_restart,
    input logic soft_reset_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire rq = mgmt_start && mgmt_addr == 5'h00;
    a_reset_value: assert property ($fell(sys_rst) |->
        phy_control == 16'h3100) else $error("bad reset value");
    a_done_pulse: assert property (mgmt_start |=> mgmt_done)
        else $error("done missing");
    a_done_idle: assert property (!mgmt_start |=> !mgmt_done)
        else $error("done without request");
    a_write_low: assert property (rq && mgmt_write |=>
        phy_control[6:0] == 7'h00) else $error("reserved bits stored");
    a_field_pins: assert property ({loopback_enable, speed_select,
        autoneg_enable, power_down, isolate, autoneg_restart} ==
        phy_control[14:9]) else $error("field pins wrong");
    a_restart_clear: assert property (phy_control[9] &&
        aneg_restart_done |=> !autoneg_restart)
        else $error("restart bit not cleared");
    a_soft_reload: assert property (phy_control[15] |=>
        phy_control == 16'h3100 && soft_reset_pulse)
        else $error("soft reset not done");
    a_soft_quiet: assert property (!phy_control[15] |=>
        !soft_reset_pulse) else $error("stray soft reset pulse");
    a_write_value: assert property (rq && mgmt_write |=>
        phy_control[15:10] == $past(mgmt_tx_holding[15:10]))
        else $error("write value lost");
    a_read_value: assert property (rq && !mgmt_write |=>
        mgmt_rx_holding == $past(phy_control)) else $error("bad read");
    a_read_hold: assert property (!(mgmt_start && !mgmt_write) |=>
        $stable(mgmt_rx_holding)) else $error("read data moved");
    a_duplex_pin: assert property (full_duplex == phy_control[8])
        else $error("duplex pin wrong");
    a_coll_pin: assert property (collision_test == phy_control[7])
        else $error("collision pin wrong");
    a_coll_set: assert property (tx_initiated |=> collision_test)
        else $error("collision test not set");
    a_coll_clear: assert property (tx_halted && !tx_initiated |=>
        !collision_test) else $error("collision test not cleared");
    a_aneg_duplex: assert property (aneg_full_resolved &&
        phy_control[12] |=> full_duplex) else $error("duplex not set");
endmodule // pcr_mon
bind pcr_phy_control pcr_mon u_mon(
    .clk(clk),
    .sys_rst(sys_rst),
    .mgmt_start(mgmt_start),
    .mgmt_write(mgmt_write),
    .mgmt_addr(mgmt_addr),
    .mgmt_tx_holding(mgmt_tx_holding),
    .mgmt_rx_holding(mgmt_rx_holding),
    .mgmt_done(mgmt_done),
    .aneg_full_resolved(aneg_full_resolved),
    .aneg_restart_done(aneg_restart_done),
    .tx_initiated(tx_initiated),
    .tx_halted(tx_halted),
    .phy_control(phy_control),
    .full_duplex(full_duplex),
    .collision_test(collision_test),
    .loopback_enable(loopback_enable),
    .speed_select(speed_select),
    .autoneg_enable(autoneg_enable),
    .power_down(power_down),
    .isolate(isolate),
    .autoneg_restart(autoneg_restart),
    .soft_reset_pulse(soft_reset_pulse)
);

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, sys_rst = 1, anf = 0, ard = 0, ti = 0, th = 0, st, wr;
    logic [4:0] ad;
    logic [15:0] tx, rx;
    int num_errors = 0, n_compared = 0;
    pcr_mac u_mac(.clk(clk), .mgmt_start(st), .mgmt_write(wr),
        .mgmt_addr(ad), .mgmt_tx_holding(tx));
    pcr_phy_control DUT(.clk(clk), .sys_rst(sys_rst), .mgmt_start(st),
        .mgmt_write(wr), .mgmt_addr(ad), .mgmt_tx_holding(tx),
        .mgmt_rx_holding(rx), .mgmt_done(), .aneg_full_resolved(anf),
        .aneg_restart_done(ard), .tx_initiated(ti), .tx_halted(th),
        .phy_control(), .full_duplex(), .collision_test(),
        .loopback_enable(), .speed_select(), .autoneg_enable(),
        .power_down(), .isolate(), .autoneg_restart(),
        .soft_reset_pulse());
    task final_report;
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task rd(input logic [4:0] a, input logic [15:0] e);
        u_mac.xfer(0, a, 16'h0000);
        n_compared++;
        if (rx !== e) begin
            num_errors++;
            $display("Error %0t got %h exp %h", $time, rx, e);
        end
    endtask
    // Event mask order: resolved full, restart done, tx start, tx halt
    task ev(input logic [3:0] m);
        @(negedge clk);
        {anf, ard, ti, th} = m;
        @(negedge clk);
        {anf, ard, ti, th} = 4'h0;
    endtask
    initial forever #20 clk = ~clk;
    initial begin
        #20000 num_errors++; // Hang guard, run needs far less
        final_report;
    end
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 0;
        rd(0, 16'h3100);
        u_mac.xfer(1, 0, 16'h007f);
        rd(0, 16'h0000);
        ev(4'h8);
        rd(0, 16'h0000);
        u_mac.xfer(1, 1, 16'h2100);
        rd(0, 16'h0000);
        u_mac.xfer(1, 0, 16'h1000);
        ev(4'h8);
        rd(0, 16'h1100);
        rd(1, 16'h0000);
        ev(4'h2);
        rd(0, 16'h1180);
        ev(4'h1);
        rd(0, 16'h1100);
        ev(4'h3);
        rd(0, 16'h1180);
        u_mac.xfer(1, 0, 16'h1300);
        rd(0, 16'h1300);
        ev(4'h4);
        rd(0, 16'h1100);
        u_mac.xfer(1, 0, 16'h9000);
        repeat (2) @(negedge clk);
        rd(0, 16'h3100);
        u_mac.xfer(1, 0, 16'h0000);
        @(negedge clk);
        sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        rd(0, 16'h3100);
        final_report;
    end
endmodule // tb_top
